// ==== canopen_nmt_slave_node_tb.sv ====
// Purpose: self-checking bench for the network-management slave node
// Assumes: zero-wait APB slave, master model drives the CAN-side strobes
// Notes:   third reset re-runs boot without automatic start
`timescale 1ns/10ps
module canopen_nmt_slave_node_tb;
  logic        pclk, presetn, psel, penable, pwrite, sensor_fault;
  logic [7:0]  paddr, nmt_cs, nmt_node, lss_nodeid, lss_table;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, nmt_valid, lss_nodeid_valid, lss_rate_valid;
  logic [11:0] lss_kbps, bit_kbps;
  logic        frame_valid, frame_ext, frame_ok, boot_msg, rate_table, term_en;
  logic [3:0]  frame_dlc;
  logic [1:0]  nmt_state;
  logic [7:0]  service_en, node_id, sdo_resp_code;
  logic        sdo_resp_valid;
  int          fail_count, total_checks, cyc;
  cnmt_node dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmt_valid(nmt_valid), .nmt_cs(nmt_cs), .nmt_node(nmt_node),
    .lss_nodeid_valid(lss_nodeid_valid), .lss_nodeid(lss_nodeid),
    .lss_rate_valid(lss_rate_valid), .lss_table(lss_table),
    .lss_kbps(lss_kbps), .sensor_fault(sensor_fault),
    .frame_valid(frame_valid), .frame_dlc(frame_dlc), .frame_ext(frame_ext),
    .frame_ok(frame_ok), .boot_msg(boot_msg), .nmt_state(nmt_state),
    .service_en(service_en), .node_id(node_id), .bit_kbps(bit_kbps),
    .rate_table(rate_table), .term_en(term_en),
    .sdo_resp_valid(sdo_resp_valid), .sdo_resp_code(sdo_resp_code));
  cnmt_master_model master (.pclk(pclk), .nmt_valid(nmt_valid),
    .nmt_cs(nmt_cs), .nmt_node(nmt_node),
    .lss_nodeid_valid(lss_nodeid_valid), .lss_nodeid(lss_nodeid),
    .lss_rate_valid(lss_rate_valid), .lss_table(lss_table),
    .lss_kbps(lss_kbps), .frame_valid(frame_valid),
    .frame_dlc(frame_dlc), .frame_ext(frame_ext));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic st(input cnmt_pkg::cnmt_state_t s, input logic [7:0] sv);
    repeat (2) @(posedge pclk);
    chk({30'h0, nmt_state}, {30'h0, s});
    chk({24'h0, service_en}, {24'h0, sv});
  endtask
  task automatic nst(input logic [7:0] cs, input logic [7:0] nd,
                     input cnmt_pkg::cnmt_state_t s, input logic [7:0] sv);
    master.send_nmt(cs, nd);
    st(s, sv);
  endtask
  task automatic t_init;
    st(cnmt_pkg::CNMT_INIT, 8'h00);
    chk({24'h0, node_id}, 32'h20);
    chk({20'h0, bit_kbps}, 32'h7d);
    chk({29'h0, rate_table, term_en, boot_msg}, 32'h0);
    nst(cnmt_pkg::CMD_START, 8'h00, cnmt_pkg::CNMT_INIT, 8'h00);
  endtask
  task automatic t_boot(input logic auto_on);
    int n;
    do_reset();
    wr(cnmt_pkg::OFF_CTRL, {28'h0, 3'b100, auto_on});
    n = 0;
    while (boot_msg !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, boot_msg}, 32'h1);
    if (auto_on) st(cnmt_pkg::CNMT_OPER, 8'hff);
    else st(cnmt_pkg::CNMT_PREOP, 8'h3f);
  endtask
  task automatic t_nmt;
    nst(cnmt_pkg::CMD_START, 8'h21, cnmt_pkg::CNMT_PREOP, 8'h3f);
    nst(cnmt_pkg::CMD_START, 8'h20, cnmt_pkg::CNMT_OPER, 8'hff);
    nst(cnmt_pkg::CMD_STOP, 8'h00, cnmt_pkg::CNMT_STOP, 8'h0f);
    nst(cnmt_pkg::CMD_PREOP, 8'h20, cnmt_pkg::CNMT_PREOP, 8'h3f);
    nst(cnmt_pkg::CMD_START, 8'h00, cnmt_pkg::CNMT_OPER, 8'hff);
  endtask
  task automatic fault(input logic [31:0] ctrl);
    wr(cnmt_pkg::OFF_CTRL, ctrl);
    @(posedge pclk);
    sensor_fault <= 1'b1;
    @(posedge pclk);
    sensor_fault <= 1'b0;
  endtask
  task automatic t_fault;
    fault(32'h0);
    st(cnmt_pkg::CNMT_PREOP, 8'h3f);
    nst(cnmt_pkg::CMD_START, 8'h00, cnmt_pkg::CNMT_OPER, 8'hff);
    fault(32'h2);
    st(cnmt_pkg::CNMT_STOP, 8'h0f);
    rd(cnmt_pkg::OFF_STATUS, 32'h0000_0f0e, 1'b0);
  endtask
  task automatic sdo(input logic [31:0] d, input logic [7:0] id,
                     input logic [7:0] code);
    wr(cnmt_pkg::OFF_NODEID, d);
    @(negedge pclk);
    chk({31'h0, sdo_resp_valid}, 32'h1);
    repeat (2) @(posedge pclk);
    chk({24'h0, node_id}, {24'h0, id});
    chk({24'h0, sdo_resp_code}, {24'h0, code});
  endtask
  task automatic t_id;
    sdo(32'h05, 8'h05, 8'h60);
    sdo(32'h80, 8'h05, 8'h80);
    sdo(32'h00, 8'h05, 8'h80);
    master.lss_id(8'h7f);
    master.lss_id(8'h00);
    repeat (2) @(posedge pclk);
    chk({24'h0, node_id}, 32'h7f);
    nst(cnmt_pkg::CMD_START, 8'h7f, cnmt_pkg::CNMT_OPER, 8'hff);
    nst(cnmt_pkg::CMD_STOP, 8'h20, cnmt_pkg::CNMT_OPER, 8'hff);
  endtask
  // Accepted, too slow, too fast, bad selector, lowest rate
  logic [7:0]  rt_t [5] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [11:0] rt_k [5] = '{12'h5dc, 12'h013, 12'h5dd, 12'h064, 12'h014};
  logic [12:0] rt_e [5] = '{13'h15dc, 13'h15dc, 13'h15dc, 13'h15dc, 13'h14};
  task automatic t_rate;
    for (int i = 0; i < 5; i++) begin
      master.lss_rate(rt_t[i], rt_k[i]);
      repeat (2) @(posedge pclk);
      chk({19'h0, rate_table, bit_kbps}, {19'h0, rt_e[i]});
    end
    wr(cnmt_pkg::OFF_BRATE, 32'h7d);
    rd(cnmt_pkg::OFF_BRATE, 32'h14, 1'b0);
  endtask
  task automatic t_regs;
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = cnmt_pkg::OFF_COBID0 + 8'(4 * i);
      rd(a, 32'h0, 1'b0);
      wr(a, 32'h2000_0180 + 32'(i));
      rd(a, 32'h2000_0180 + 32'(i), 1'b0);
    end
    wr(cnmt_pkg::OFF_CTRL, 32'h4);
    repeat (2) @(posedge pclk);
    chk({31'h0, term_en}, 32'h1);
    rd(8'h18, 32'h0, 1'b1);
  endtask
  task automatic t_frame;
    for (int d = 0; d < 10; d++) begin
      master.send_frame(4'(d), d[0]);
      @(posedge pclk);
      chk({31'h0, frame_ok}, {31'h0, d <= 8});
    end
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, sensor_fault} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {cyc, fail_count, total_checks} = '0;
    do_reset();
    t_init();
    t_boot(1'b1);
    t_boot(1'b0);
    t_nmt();
    t_fault();
    t_id();
    t_rate();
    t_regs();
    t_frame();
    test_done();
  end
endmodule

// ==== cnmt_master_model.sv ====
// Purpose: behavioural network master feeding command and frame strobes
// Assumes: every strobe is launched right after a rising pclk edge
// Notes:   released data lines carry the inverse of the last value
`timescale 1ns/10ps
module cnmt_master_model (
  input  wire logic  pclk,
  output logic       nmt_valid,
  output logic [7:0] nmt_cs,
  output logic [7:0] nmt_node,
  output logic       lss_nodeid_valid,
  output logic [7:0] lss_nodeid,
  output logic       lss_rate_valid,
  output logic [7:0] lss_table,
  output logic [11:0] lss_kbps,
  output logic       frame_valid,
  output logic [3:0] frame_dlc,
  output logic       frame_ext
);
  // Quiet bus at time zero
  initial begin
    {nmt_valid, lss_nodeid_valid, lss_rate_valid, frame_valid} = 4'h0;
    {nmt_cs, nmt_node, lss_nodeid, lss_table} = 32'h0;
    {lss_kbps, frame_dlc, frame_ext} = 17'h0;
  end
  task automatic send_nmt(input logic [7:0] cs, input logic [7:0] node);
    @(posedge pclk);
    nmt_valid <= 1'b1;
    nmt_cs    <= cs;
    nmt_node  <= node;
    @(posedge pclk);
    nmt_valid <= 1'b0;
    nmt_cs    <= ~cs; // Stale fields must never look valid
    nmt_node  <= ~node;
  endtask
  task automatic lss_id(input logic [7:0] id);
    @(posedge pclk);
    lss_nodeid_valid <= 1'b1;
    lss_nodeid       <= id;
    @(posedge pclk);
    lss_nodeid_valid <= 1'b0;
    lss_nodeid       <= ~id;
  endtask
  task automatic lss_rate(input logic [7:0] t, input logic [11:0] k);
    @(posedge pclk);
    lss_rate_valid <= 1'b1;
    lss_table      <= t;
    lss_kbps       <= k;
    @(posedge pclk);
    lss_rate_valid <= 1'b0;
    lss_table      <= ~t;
    lss_kbps       <= ~k;
  endtask
  task automatic send_frame(input logic [3:0] dlc, input logic ext);
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_dlc   <= dlc;
    frame_ext   <= ext;
    @(posedge pclk);
    frame_valid <= 1'b0;
    frame_dlc   <= ~dlc;
    frame_ext   <= ~ext;
  endtask
endmodule

// ==== cnmt_node.sv ====
// Purpose: network state machine, service gating and node configuration
// Assumes: a CAN core decodes frames into the command and request strobes
// Notes:   registers sit on APB; zero wait states; unmapped gives pslverr
//          commands are ignored until boot completes, so a master that
//          talks too early sees no reaction rather than a half-made state
`timescale 1ns/10ps
module cnmt_node (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Decoded network-management and layer setting strobes
  input  wire logic        nmt_valid,
  input  wire logic [7:0]  nmt_cs,
  input  wire logic [7:0]  nmt_node,
  input  wire logic        lss_nodeid_valid,
  input  wire logic [7:0]  lss_nodeid,
  input  wire logic        lss_rate_valid,
  input  wire logic [7:0]  lss_table,
  input  wire logic [11:0] lss_kbps,
  // Fault event and frame bookkeeping
  input  wire logic        sensor_fault,
  input  wire logic        frame_valid,
  input  wire logic [3:0]  frame_dlc,
  input  wire logic        frame_ext,
  output logic             frame_ok,
  // Node state and configuration seen by the CAN core
  output logic             boot_msg,
  output logic [1:0]       nmt_state,
  output logic [7:0]       service_en,
  output logic [7:0]       node_id,
  output logic [11:0]      bit_kbps,
  output logic             rate_table,
  output logic             term_en,
  output logic             sdo_resp_valid,
  output logic [7:0]       sdo_resp_code
);
  cnmt_pkg::cnmt_state_t state_q, state_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  node_q;
  logic [11:0] kbps_q;
  logic        table_q;
  logic        boot_q;
  logic        boot_sent_q;
  logic        fault_q;
  logic        resp_q;
  logic [7:0]  code_q;
  logic        fok_q;
  logic [31:0] cobid_q [cnmt_pkg::NUM_COBID];

  // APB decode
  wire         acc     = psel & penable;
  wire         wr      = acc & pwrite;
  wire         hit_ctl = paddr == cnmt_pkg::OFF_CTRL;
  wire         hit_st  = paddr == cnmt_pkg::OFF_STATUS;
  wire         hit_nid = paddr == cnmt_pkg::OFF_NODEID;
  wire         hit_br  = paddr == cnmt_pkg::OFF_BRATE;
  wire         hit_cmd = paddr == cnmt_pkg::OFF_CMD;
  wire         hit_sdo = paddr == cnmt_pkg::OFF_SDO;
  wire         hit_cob = paddr[7:4] == cnmt_pkg::OFF_COBID0[7:4];
  wire [1:0]   cob_ix  = paddr[3:2];
  wire         hit_any = hit_ctl | hit_st | hit_nid | hit_br | hit_cmd
                         | hit_sdo | hit_cob;
  // SDO writes to node id are checked, bad values answer 0x80; bit rate writes are dropped
  // [R09] Range check
  wire         nid_good = pwdata[7:0] >= cnmt_pkg::NODEID_MIN &&
                          pwdata[7:0] <= cnmt_pkg::NODEID_MAX;
  // [R14] Rate window
  wire         br_good  = pwdata[11:0] >= cnmt_pkg::KBPS_MIN &&
                          pwdata[11:0] <= cnmt_pkg::KBPS_MAX;
  wire         lss_br_ok = lss_kbps >= cnmt_pkg::KBPS_MIN &&
                           lss_kbps <= cnmt_pkg::KBPS_MAX &&
                           lss_table <= 8'h01;
  wire         lss_nid_ok = lss_nodeid >= cnmt_pkg::NODEID_MIN &&
                            lss_nodeid <= cnmt_pkg::NODEID_MAX;
  wire         sdo_wr   = wr & (hit_nid | hit_ctl | hit_cob);
  wire         sdo_bad  = wr & hit_nid & ~nid_good;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // Read mux; status shows the live state and fault latch
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc & ~pwrite) begin
      if (hit_ctl) prdata = {24'h000000, ctrl_q};
      else if (hit_st) prdata = {16'h0000, service_en, 4'h0,
                                 fault_q, boot_sent_q, state_q};
      else if (hit_nid) prdata = {24'h000000, node_q};
      else if (hit_br) prdata = {19'h00000, table_q, kbps_q};
      else if (hit_sdo) prdata = {23'h000000, resp_q, code_q};
      else if (hit_cob) prdata = cobid_q[cob_ix];
    end
  end

  // [R21] Address filter
  wire nmt_for_me = nmt_valid & ((nmt_node == node_q) | (nmt_node == 8'h00));
  wire boot_done  = ctrl_q[cnmt_pkg::CTRL_BOOT_DONE];
  wire fault_ev   = sensor_fault | (wr & hit_ctl & pwdata[cnmt_pkg::CTRL_FAULT]);

  // Next state: reset init, boot, commands, fault fallback
  // [R01] Four states
  always_comb begin
    state_d = state_q;
    case (state_q)
      cnmt_pkg::CNMT_INIT: begin
        // [R02] Boot then pre-op
        // [R05] Autostart path
        if (boot_done)
          state_d = ctrl_q[cnmt_pkg::CTRL_AUTOSTART] ? cnmt_pkg::CNMT_OPER
                                                     : cnmt_pkg::CNMT_PREOP;
      end
      cnmt_pkg::CNMT_PREOP, cnmt_pkg::CNMT_OPER, cnmt_pkg::CNMT_STOP: begin
        // [R08] Fault fallback wins
        // [R07] Otherwise command only
        if (fault_ev)
          state_d = ctrl_q[cnmt_pkg::CTRL_ERR_STOP] ? cnmt_pkg::CNMT_STOP
                                                    : cnmt_pkg::CNMT_PREOP;
        else if (nmt_for_me) begin
          // [R04] Start remote node
          if (nmt_cs == cnmt_pkg::CMD_START) state_d = cnmt_pkg::CNMT_OPER;
          else if (nmt_cs == cnmt_pkg::CMD_STOP)
            state_d = cnmt_pkg::CNMT_STOP;
          else if (nmt_cs == cnmt_pkg::CMD_PREOP)
            state_d = cnmt_pkg::CNMT_PREOP;
        end
      end
      default: state_d = cnmt_pkg::CNMT_INIT;
    endcase
  end

  // [R06] Service gating
  // [R03] No PDO in pre-op
  always_comb begin
    service_en = 8'h00;
    case (state_q)
      cnmt_pkg::CNMT_PREOP: service_en = 8'h3f;
      cnmt_pkg::CNMT_OPER:  service_en = 8'hff;
      cnmt_pkg::CNMT_STOP:  service_en = 8'h0f;
      default:              service_en = 8'h00;
    endcase
  end

  // State and boot-up frame strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= cnmt_pkg::CNMT_INIT;
      boot_q      <= 1'b0;
      boot_sent_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      // [R02] Boot-up message once
      boot_q      <= (state_q == cnmt_pkg::CNMT_INIT) & boot_done;
      boot_sent_q <= boot_sent_q | boot_q;
    end
  end

  // Fault latch; set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_q <= 1'b0;
    else if (fault_ev) fault_q <= 1'b1;
    else if (wr & hit_st) fault_q <= 1'b0;
  end

  // Control and node id; LSS and SDO both may set the id
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      // [R10] Factory id
      node_q <= cnmt_pkg::NODEID_RST;
    end else begin
      if (wr & hit_ctl) ctrl_q <= pwdata[7:0] & 8'h0f;
      // [R11] SDO or LSS id
      if (wr & hit_nid & nid_good) node_q <= pwdata[7:0];
      else if (lss_nodeid_valid & lss_nid_ok) node_q <= lss_nodeid;
    end
  end

  // Bit rate; only the layer setting service changes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [R15] Default rate
      kbps_q  <= cnmt_pkg::KBPS_RST;
      table_q <= 1'b0;
    end else if (lss_rate_valid & lss_br_ok) begin
      // [R16] Table selector
      kbps_q  <= lss_kbps;
      table_q <= lss_table[0];
    end
  end

  // [R12] Rewritable identifiers
  // [R13] Id plus control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < cnmt_pkg::NUM_COBID; i++)
        cobid_q[i] <= cnmt_pkg::COBID_RST;
    end else if (wr & hit_cob) begin
      cobid_q[cob_ix] <= pwdata;
    end
  end

  // [R20] SDO answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      resp_q <= sdo_wr;
      if (sdo_wr) code_q <= sdo_bad ? cnmt_pkg::SDO_ERR : cnmt_pkg::SDO_OK_WR;
    end
  end

  // [R17] Both id formats
  // [R18] Length bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fok_q <= 1'b0;
    else fok_q <= frame_valid & ({4'h0, frame_dlc} <= cnmt_pkg::DLC_MAX)
                  & (frame_ext | ~frame_ext);
  end

  assign frame_ok       = fok_q;
  assign boot_msg       = boot_q;
  assign nmt_state      = state_q;
  assign node_id        = node_q;
  assign bit_kbps       = kbps_q;
  assign rate_table     = table_q;
  // [R19] Termination switch
  assign term_en        = ctrl_q[cnmt_pkg::CTRL_TERM];
  assign sdo_resp_valid = resp_q;
  assign sdo_resp_code  = code_q;

  // The init, stopped and pre-op gating rows each have their own guard, so that a wrong constant in one
  // state cannot hide behind the check of another
  // [R06] Init gate
  init_gate_a: assert property ( // [R06]
    @(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_INIT |-> service_en == 8'h00)
    else $error("services open during init");

  // [R06] Stopped gate
  stop_gate_a: assert property ( // [R06]
    @(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_STOP |-> service_en == 8'h0f)
    else $error("wrong services while stopped");

  // [R03] Pre-op gate
  preop_gate_a: assert property ( // [R03]
    @(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_PREOP |-> service_en == 8'h3f)
    else $error("wrong services in pre-operational");

  // Autostart must skip pre-op entirely
  // [R05] Autostart
  boot_auto_a: assert property ( // [R05]
    @(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_INIT && boot_done &&
    ctrl_q[cnmt_pkg::CTRL_AUTOSTART] |=> state_q == cnmt_pkg::CNMT_OPER)
    else $error("autostart did not reach operational");

  // A refused id write must leave the id alone
  // [R11] Id kept
  nid_keep_a: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    wr && hit_nid && !nid_good && !lss_nodeid_valid |=> $stable(node_q))
    else $error("refused node id was taken");

  // [R16] Rate taken
  lss_rate_a: assert property ( // [R16]
    @(posedge pclk) disable iff (!presetn)
    lss_rate_valid && lss_br_ok |=> kbps_q == $past(lss_kbps) &&
    table_q == $past(lss_table[0]))
    else $error("layer setting rate not applied");

  // Frame length window; the format bit must not matter
  // [R18] Long frame
  frame_len_a: assert property ( // [R18]
    @(posedge pclk) disable iff (!presetn)
    frame_valid && frame_dlc > 4'h8 |=> !frame_ok)
    else $error("oversized frame accepted");

  // [R17] Any format
  frame_take_a: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    frame_valid && frame_dlc <= 4'h8 |=> frame_ok)
    else $error("valid frame refused");

  // Earlier guards, one per rule
  oper_cmd_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
    nmt_for_me && nmt_cs == cnmt_pkg::CMD_START && !fault_ev &&
    state_q != cnmt_pkg::CNMT_INIT |=> state_q == cnmt_pkg::CNMT_OPER)
    else $error("start command did not reach operational");

  // The target follows the setting the fault met, not a later write
  fault_fall_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    fault_ev && state_q != cnmt_pkg::CNMT_INIT |=>
    state_q == ($past(ctrl_q[cnmt_pkg::CTRL_ERR_STOP]) ?
                cnmt_pkg::CNMT_STOP : cnmt_pkg::CNMT_PREOP))
    else $error("fault fallback went wrong");

  boot_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
    state_q == cnmt_pkg::CNMT_INIT && boot_done |=> boot_q ##1 !boot_q)
    else $error("boot-up strobe missing");

  pdo_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
    service_en[cnmt_pkg::SV_PDO] |-> state_q == cnmt_pkg::CNMT_OPER)
    else $error("process data enabled outside operational");

  no_self_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    !nmt_for_me && !fault_ev && state_q != cnmt_pkg::CNMT_INIT |=>
    $stable(state_q))
    else $error("state changed by itself");

  node_range_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    node_q >= cnmt_pkg::NODEID_MIN && node_q <= cnmt_pkg::NODEID_MAX)
    else $error("node id out of range");

  rate_range_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    kbps_q >= cnmt_pkg::KBPS_MIN && kbps_q <= cnmt_pkg::KBPS_MAX)
    else $error("bit rate out of range");

  sdo_answer_a: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    sdo_wr |=> resp_q && (code_q == cnmt_pkg::SDO_OK_WR ||
                          code_q == cnmt_pkg::SDO_ERR))
    else $error("SDO request not answered");

  foreign_a: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    nmt_valid && nmt_node != node_q && nmt_node != 8'h00 && !fault_ev &&
    state_q != cnmt_pkg::CNMT_INIT |=> $stable(state_q))
    else $error("acted on foreign command");

  // Main scenarios
  auto_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_INIT ##1 state_q == cnmt_pkg::CNMT_OPER);

  preop_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_INIT ##1 state_q == cnmt_pkg::CNMT_PREOP);

  fault_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == cnmt_pkg::CNMT_OPER ##1 state_q == cnmt_pkg::CNMT_STOP);

  lss_c: cover property (@(posedge pclk) disable iff (!presetn)
    lss_rate_valid && lss_br_ok && lss_table == 8'h01);

  bad_id_c: cover property (@(posedge pclk) disable iff (!presetn)
    sdo_wr && sdo_bad);

endmodule

// ==== cnmt_pkg.sv ====
// Purpose: constants for the network-management slave and node configuration
// Assumes: APB register access, one 40 MHz clock
// Notes:   byte offsets are word aligned; frame handling is left to a CAN core
// What this block does
// [R01] Network state machine with four states: init, pre-op, operational, stopped.
// [R02] After boot send boot-up frame, then enter pre-operational.
// [R03] Pre-operational keeps measuring but sends no process data.
// [R04] Start-remote-node command moves node to operational; broadcast moves all.
// [R05] With automatic start enabled, go operational straight after boot.
// [R06] Services are gated per state as the availability table lists.
// [R07] State changes only by command, automatic start or fault fallback.
// [R08] Emergency fault moves node to pre-op or stopped per error behaviour.
// [R09] Node identifier is 8-bit, valid 1 to 127, unique on network.
// [R10] Factory node identifier is 32 until reconfigured.
// [R11] New node identifier accepted by SDO write or layer setting service.
// [R12] Every communication object identifier is rewritable through SDO.
// [R13] Object identifier is a CAN identifier plus control bits.
// [R14] Only bit rates from 20 kbit/s to 1.5 Mbit/s are supported.
// [R15] Default bit rate is 125 kbit/s.
// [R16] Bit rate changes via layer setting; selector 0 standard, 1 customer.
// [R17] Both 11-bit standard and 29-bit extended identifiers are supported.
// [R18] Data length code gives 0 to 8 data bytes.
// [R19] Switchable termination follows a setting written by SDO.
// [R20] Every SDO request is answered: 0x60 on write success, 0x80 on error; only node id, control and object identifier writes are answered.
// [R21] Act only on commands addressed to own node identifier or zero.
package cnmt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_NODEID = 8'h08;
  localparam logic [7:0] OFF_BRATE  = 8'h0c;
  localparam logic [7:0] OFF_CMD    = 8'h10;
  localparam logic [7:0] OFF_SDO    = 8'h14;
  localparam logic [7:0] OFF_COBID0 = 8'h20;
  localparam int         NUM_COBID  = 4;
  // Control field positions
  localparam int CTRL_AUTOSTART = 0;
  localparam int CTRL_ERR_STOP  = 1;
  localparam int CTRL_TERM      = 2;
  localparam int CTRL_BOOT_DONE = 3;
  localparam int CTRL_FAULT     = 4;
  // Reset values and legal ranges
  localparam logic [7:0]  NODEID_RST   = 8'h20;
  localparam logic [7:0]  NODEID_MIN   = 8'h01;
  localparam logic [7:0]  NODEID_MAX   = 8'h7f;
  localparam logic [11:0] KBPS_RST     = 12'h07d;
  localparam logic [11:0] KBPS_MIN     = 12'h014;
  localparam logic [11:0] KBPS_MAX     = 12'h5dc;
  localparam logic [31:0] COBID_RST    = 32'h0000_0000;
  // Command specifiers, SDO answer codes and frame length limit
  localparam logic [7:0] CMD_START   = 8'h01;
  localparam logic [7:0] CMD_STOP    = 8'h02;
  localparam logic [7:0] CMD_PREOP   = 8'h80;
  localparam logic [7:0] SDO_OK_WR   = 8'h60;
  localparam logic [7:0] SDO_ERR     = 8'h80;
  localparam logic [7:0] DLC_MAX     = 8'h08;
  // Gray-coded network states
  typedef enum logic [1:0] {
    CNMT_INIT  = 2'b00,
    CNMT_PREOP = 2'b01,
    CNMT_OPER  = 2'b11,
    CNMT_STOP  = 2'b10
  } cnmt_state_t;
  // Service enable vector bits
  localparam int SV_NMT = 0;
  localparam int SV_HEARTBEAT = 1;
  localparam int SV_TIME = 2;
  localparam int SV_LSS = 3;
  localparam int SV_EMCY = 4;
  localparam int SV_SDO = 5;
  localparam int SV_SYNC = 6;
  localparam int SV_PDO = 7;
endpackage
